// [hdl/mfpe_engine.sv]
// Half-duplex packet engine: framing toward the modulator, deframing into the buffer.
`timescale 1ns/1ps
`default_nettype none
module mfpe_engine #(
    parameter int CRC_W = 16
) (
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic        select_frame_family_cmd,
    input  wire logic [1:0]  family_sel,
    input  wire logic        configure_frame_params_cmd,
    input  wire logic [7:0]  fixed_frame_byte_count,
    input  wire logic [3:0]  preamble_nibble_count,
    input  wire logic [15:0] css_preamble_symbols,
    input  wire logic        variable_length,
    input  wire logic        whiten_enable,
    input  wire logic        crc_enable,
    input  wire logic [2:0]  coded_crc_bytes,
    input  wire logic [1:0]  coding_rate,
    input  wire logic [1:0]  coded_type_field,
    input  wire logic        start_tx,
    input  wire logic        start_rx,
    input  wire logic [7:0]  buf_rd_data,
    input  wire logic        air_rx_valid,
    input  wire logic [7:0]  air_rx_byte,
    input  wire logic        mod_ready,
    output logic             mod_valid,
    output logic [7:0]       mod_byte,
    output logic [1:0]       mod_field,
    output logic             buf_rd,
    output logic             buf_wr,
    output logic [7:0]       buf_wr_data,
    output logic             tx_active,
    output logic             rx_active,
    output logic             frame_done,
    output logic             crc_ok,
    output logic             header_err,
    output logic [1:0]       family,
    output logic [15:0]      preamble_units
);
    ////////////////////////////////////////////////////////////////////////////////
    mfpe_pkg::mfpe_state_t state;
    mfpe_pkg::mfpe_state_t next_state;
    logic [15:0] cnt;
    logic [15:0] next_cnt;
    logic [7:0]  len;
    logic [7:0]  next_len;
    logic [7:0]  hdr0;
    logic [7:0]  next_hdr0;
    logic        is_tx;
    logic        next_is_tx;
    logic        next_mod_valid;
    logic [7:0]  next_mod_byte;
    logic [1:0]  next_mod_field;
    logic        next_buf_rd;
    logic        next_buf_wr;
    logic [7:0]  next_buf_wr_data;
    logic        next_frame_done;
    logic        next_crc_ok;
    logic        next_header_err;
    logic [1:0]  next_family;
    logic [15:0] next_preamble_units;
    logic        crc_clear;
    logic        crc_step;
    logic [7:0]  crc_din;
    logic [7:0]  crc_dout;
    logic [CRC_W-1:0] crc_val;
    logic        wh_en;
    logic [2:0]  crc_len;
    logic        tail_on;
    logic        busy;
    logic        beat;

    localparam logic [1:0] CR_FIELD = mfpe_pkg::CR_STRONGEST;

    mfpe_crc #(.W(CRC_W)) u_crc (
        .ref_clk   (ref_clk),
        .sys_rst   (sys_rst),
        .clear     (crc_clear),
        .step      (crc_step),
        .din       (crc_din),
        .whiten_en (wh_en),
        .dout      (crc_dout),
        .crc       (crc_val)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Frame-family dependent sizes.
    always_comb begin
        busy    = (state != mfpe_pkg::ST_IDLE);
        wh_en   = whiten_enable && (family == mfpe_pkg::FAM_FSK);
        tail_on = (coding_rate == mfpe_pkg::CR_HALF) ||
            (coding_rate == mfpe_pkg::CR_3Q);
        unique case (family)
            mfpe_pkg::FAM_LEW:   crc_len = mfpe_pkg::LEW_CRC_BYTES;
            mfpe_pkg::FAM_CODED: crc_len = coded_crc_bytes;
            default:             crc_len = crc_enable ? 3'(CRC_W / 8) : 3'h0;
        endcase
        // A byte moves when no byte is pending or the modulator takes the pending one, or when the demodulator offers one.
        beat = is_tx ? (mod_ready || !mod_valid) : air_rx_valid;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration: family first, then parameters interpreted per family.
    always_comb begin
        next_family = family;
        next_preamble_units = preamble_units;
        if (select_frame_family_cmd && !busy) begin
            next_family = family_sel;
        end
        if (configure_frame_params_cmd && !busy) begin
            unique case (family)
                mfpe_pkg::FAM_CSS: begin
                    // Counts below the minimum fall back to the minimum instead of being stored; there is no upper limit.
                    next_preamble_units = (css_preamble_symbols < mfpe_pkg::CSS_PRE_MIN) ?
                        mfpe_pkg::CSS_PRE_MIN : css_preamble_symbols;
                end
                mfpe_pkg::FAM_LEW:   next_preamble_units = 16'(mfpe_pkg::LEW_PRE_NIB);
                default: begin
                    if (preamble_nibble_count < mfpe_pkg::PRE_NIB_MIN) begin
                        next_preamble_units = 16'(mfpe_pkg::PRE_NIB_MIN);
                    end else if (preamble_nibble_count > mfpe_pkg::PRE_NIB_MAX) begin
                        next_preamble_units = 16'(mfpe_pkg::PRE_NIB_MAX);
                    end else begin
                        next_preamble_units = 16'(preamble_nibble_count);
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            family         <= mfpe_pkg::FAM_FSK;
            preamble_units <= mfpe_pkg::CSS_PRE_DEFAULT;
        end else begin
            family         <= next_family;
            preamble_units <= next_preamble_units;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Frame sequencer: one fields walk serves both directions.
    always_comb begin
        next_state       = state;
        next_cnt         = cnt;
        next_len         = len;
        next_hdr0        = hdr0;
        next_is_tx       = is_tx;
        next_mod_valid   = mod_valid && !mod_ready;
        next_mod_byte    = mod_byte;
        next_mod_field   = mod_field;
        next_buf_rd      = 1'b0;
        next_buf_wr      = 1'b0;
        next_buf_wr_data = buf_wr_data;
        next_frame_done  = 1'b0;
        next_crc_ok      = crc_ok;
        next_header_err  = header_err;
        crc_clear        = 1'b0;
        crc_step         = 1'b0;
        crc_din          = is_tx ? buf_rd_data : air_rx_byte;
        unique case (state)
            mfpe_pkg::ST_IDLE: begin
                // Transmit wins a simultaneous start; only one direction runs.
                if (start_tx || start_rx) begin
                    next_is_tx      = start_tx;
                    next_state      = mfpe_pkg::ST_PRE;
                    next_cnt        = '0;
                    next_len        = (family == mfpe_pkg::FAM_CODED && fixed_frame_byte_count <
                        mfpe_pkg::CODED_PAY_MIN) ? mfpe_pkg::CODED_PAY_MIN :
                        (family == mfpe_pkg::FAM_CODED && fixed_frame_byte_count >
                        mfpe_pkg::CODED_PAY_MAX) ? mfpe_pkg::CODED_PAY_MAX :
                        fixed_frame_byte_count;
                    next_header_err = 1'b0;
                    next_crc_ok     = 1'b0;
                    crc_clear       = 1'b1;
                end
            end
            mfpe_pkg::ST_PRE: begin
                // Preamble beats of 8'h55 are sent to the modulator on field 0; counted here in modem units.
                if (beat) begin
                    next_mod_valid = is_tx;
                    next_mod_byte  = 8'h55;
                    next_mod_field = 2'h0;
                    next_cnt       = cnt + 16'h1;
                    if (cnt + 16'h1 >= preamble_units) begin
                        next_cnt   = '0;
                        next_state = (family == mfpe_pkg::FAM_CSS) ?
                            mfpe_pkg::ST_HDR : mfpe_pkg::ST_SYNC;
                    end
                end
            end
            mfpe_pkg::ST_SYNC: begin
                if (beat) begin
                    next_mod_valid = is_tx;
                    next_mod_byte  = 8'hd3;
                    next_mod_field = 2'h1;
                    next_cnt       = cnt + 16'h1;
                    if (cnt + 16'h1 >= 16'(mfpe_pkg::LEW_SYNC_BYTES)) begin
                        next_cnt   = '0;
                        next_state = (variable_length && family != mfpe_pkg::FAM_LEW) ?
                            mfpe_pkg::ST_HDR : mfpe_pkg::ST_PAY;
                        next_buf_rd = is_tx && (!variable_length || family == mfpe_pkg::FAM_LEW);
                    end
                end
            end
            mfpe_pkg::ST_HDR: begin
                // Header bytes: FSK one length byte, coded two bytes, spread two bytes.
                if (variable_length && beat) begin
                    crc_step       = 1'b1;
                    crc_din        = is_tx ? ((cnt == 16'h0) ?
                        ((family == mfpe_pkg::FAM_CODED) ? {6'h0, coded_type_field} : len) :
                        ((family == mfpe_pkg::FAM_CSS) ? ~len : len)) :
                        air_rx_byte;
                    next_mod_valid = is_tx;
                    next_mod_byte  = crc_dout;
                    next_mod_field = (family == mfpe_pkg::FAM_CSS) ? CR_FIELD : 2'h2;
                    if (!is_tx && cnt == 16'h0) begin
                        next_hdr0 = air_rx_byte;
                    end
                    next_cnt = cnt + 16'h1;
                    if (family == mfpe_pkg::FAM_FSK ||
                        cnt == 16'(mfpe_pkg::CSS_HDR_BYTES - 2'h1)) begin
                        if (!is_tx) begin
                            next_len = (family == mfpe_pkg::FAM_CSS) ?
                                hdr0 : air_rx_byte;
                            // Spread header check: second byte must echo first inverted.
                            if (family == mfpe_pkg::FAM_CSS && air_rx_byte != ~hdr0) begin
                                next_header_err = 1'b1;
                            end
                        end
                        next_cnt    = '0;
                        next_state  = (!is_tx && family == mfpe_pkg::FAM_CSS &&
                            air_rx_byte != ~hdr0) ? mfpe_pkg::ST_DONE : mfpe_pkg::ST_PAY;
                        next_buf_rd = is_tx;
                    end
                end else if (!variable_length) begin
                    next_state  = mfpe_pkg::ST_PAY;
                    next_buf_rd = is_tx;
                end
            end
            mfpe_pkg::ST_PAY: begin
                if (cnt >= 16'(len)) begin
                    next_cnt   = '0;
                    next_state = (crc_len == 3'h0) ? mfpe_pkg::ST_TAIL : mfpe_pkg::ST_CRC;
                end else if (beat && !buf_rd) begin
                    crc_step       = 1'b1;
                    next_mod_valid = is_tx;
                    next_mod_byte  = crc_dout;
                    next_mod_field = 2'h2;
                    next_buf_wr    = !is_tx;
                    next_buf_wr_data = crc_dout;
                    next_buf_rd    = is_tx && (cnt + 16'h1 < 16'(len));
                    next_cnt       = cnt + 16'h1;
                end
            end
            mfpe_pkg::ST_CRC: begin
                if (beat) begin
                    next_mod_valid = is_tx;
                    next_mod_byte  = cnt[0] ? crc_val[7:0] : crc_val[CRC_W-1 -: 8];
                    next_mod_field = 2'h3;
                    crc_step       = !is_tx;
                    next_cnt       = cnt + 16'h1;
                    if (cnt + 16'h1 >= 16'(crc_len)) begin
                        next_cnt   = '0;
                        next_state = mfpe_pkg::ST_TAIL;
                    end
                end
            end
            mfpe_pkg::ST_TAIL: begin
                // Residue zero after the CRC bytes passes through the register means intact.
                if (!is_tx) begin
                    next_crc_ok = (crc_len == 3'h0) || (crc_val == '0);
                end
                if (!(is_tx && family == mfpe_pkg::FAM_CODED && tail_on)) begin
                    next_state = mfpe_pkg::ST_DONE;
                end else if (beat) begin
                    next_mod_valid = 1'b1;
                    next_mod_byte  = 8'h00;
                    next_mod_field = 2'h3;
                    next_state     = mfpe_pkg::ST_DONE;
                end
            end
            mfpe_pkg::ST_DONE: begin
                if (!mod_valid) begin
                    next_frame_done = 1'b1;
                    next_state      = mfpe_pkg::ST_IDLE;
                end
            end
            default: next_state = mfpe_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state       <= mfpe_pkg::ST_IDLE;
            cnt         <= '0;
            len         <= '0;
            hdr0        <= '0;
            is_tx       <= 1'b0;
            mod_valid   <= 1'b0;
            mod_byte    <= '0;
            mod_field   <= '0;
            buf_rd      <= 1'b0;
            buf_wr      <= 1'b0;
            buf_wr_data <= '0;
            frame_done  <= 1'b0;
            crc_ok      <= 1'b0;
            header_err  <= 1'b0;
            tx_active   <= 1'b0;
            rx_active   <= 1'b0;
        end else begin
            state       <= next_state;
            cnt         <= next_cnt;
            len         <= next_len;
            hdr0        <= next_hdr0;
            is_tx       <= next_is_tx;
            mod_valid   <= next_mod_valid;
            mod_byte    <= next_mod_byte;
            mod_field   <= next_mod_field;
            buf_rd      <= next_buf_rd;
            buf_wr      <= next_buf_wr;
            buf_wr_data <= next_buf_wr_data;
            frame_done  <= next_frame_done;
            crc_ok      <= next_crc_ok;
            header_err  <= next_header_err;
            tx_active   <= (next_state != mfpe_pkg::ST_IDLE) && next_is_tx;
            rx_active   <= (next_state != mfpe_pkg::ST_IDLE) && !next_is_tx;
        end
    end
endmodule
`default_nettype wire

// [hdl/mfpe_pkg.sv]
// Package of constants and types for the multi-format packet engine.
package mfpe_pkg;
    typedef enum logic [1:0] {
        FAM_FSK   = 2'h0,
        FAM_LEW   = 2'h1,
        FAM_CODED = 2'h2,
        FAM_CSS   = 2'h3
    } mfpe_family_t;

    typedef enum logic [7:0] {
        ST_IDLE  = 8'h01,
        ST_PRE   = 8'h02,
        ST_SYNC  = 8'h04,
        ST_HDR   = 8'h08,
        ST_PAY   = 8'h10,
        ST_CRC   = 8'h20,
        ST_TAIL  = 8'h40,
        ST_DONE  = 8'h80
    } mfpe_state_t;

    localparam logic [3:0]  PRE_NIB_MIN     = 4'h1;
    localparam logic [3:0]  PRE_NIB_MAX     = 4'h8;
    localparam logic [3:0]  LEW_PRE_NIB     = 4'h2;
    localparam logic [2:0]  LEW_SYNC_BYTES  = 3'h4;
    localparam logic [2:0]  LEW_CRC_BYTES   = 3'h3;
    localparam logic [2:0]  CODED_SYNC_BYTES = 3'h4;
    localparam logic [2:0]  CODED_CRC_MIN   = 3'h2;
    localparam logic [2:0]  CODED_CRC_MAX   = 3'h4;
    localparam logic [7:0]  CODED_PAY_MIN   = 8'h06;
    localparam logic [7:0]  CODED_PAY_MAX   = 8'h7f;
    localparam logic [4:0]  CODED_TRP_BITS  = 5'h15;
    localparam logic [2:0]  CODED_TAIL_BITS = 3'h6;
    localparam logic [1:0]  CODED_HDR_BYTES = 2'h2;
    localparam logic [1:0]  CODED_TYPE_BITS = 2'h2;
    localparam logic [15:0] CSS_PRE_DEFAULT = 16'h000c;
    localparam logic [15:0] CSS_PRE_MIN     = 16'h0008;
    localparam logic [3:0]  CSS_HDR_SYMS    = 4'h8;
    localparam logic [3:0]  CSS_EXTRA_QSYM  = 4'h1;
    localparam logic [1:0]  CSS_HDR_BYTES   = 2'h2;
    localparam logic [1:0]  CR_STRONGEST    = 2'h3;
    localparam logic [1:0]  CR_HALF         = 2'h1;
    localparam logic [1:0]  CR_3Q           = 2'h2;
    localparam logic [7:0]  WHITEN_SEED     = 8'hff;
    localparam logic [15:0] CRC16_POLY      = 16'h1021;
    localparam logic [15:0] CRC_SEED        = 16'hffff;
endpackage

// [hdl/mfpe_crc.sv]
// Serial byte-wide CRC and whitening stage shared by transmit and receive.
`timescale 1ns/1ps
`default_nettype none
module mfpe_crc #(
    parameter int W = 16
) (
    input  wire logic         ref_clk,
    input  wire logic         sys_rst,
    input  wire logic         clear,
    input  wire logic         step,
    input  wire logic [7:0]   din,
    input  wire logic         whiten_en,
    output logic [7:0]        dout,
    output logic [W-1:0]      crc
);
    logic [W-1:0] next_crc;
    logic [7:0]   lfsr;
    logic [7:0]   next_lfsr;

    always_comb begin
        logic [W-1:0] c;
        logic [7:0]   l;
        c = crc;
        l = lfsr;
        for (int i = 7; i >= 0; i--) begin
            c = {c[W-2:0], 1'b0} ^ ((c[W-1] ^ din[i]) ? W'(mfpe_pkg::CRC16_POLY) : '0);
            l = {l[6:0], l[7] ^ l[3]};
        end
        next_crc = clear ? W'(mfpe_pkg::CRC_SEED) : (step ? c : crc);
        next_lfsr = clear ? mfpe_pkg::WHITEN_SEED : (step ? l : lfsr);
        dout = whiten_en ? (din ^ lfsr) : din;
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            crc  <= W'(mfpe_pkg::CRC_SEED);
            lfsr <= mfpe_pkg::WHITEN_SEED;
        end else begin
            crc  <= next_crc;
            lfsr <= next_lfsr;
        end
    end
endmodule
`default_nettype wire

// [tb/mfpe_sva.sv]
// Assertion checker bound to the packet engine ports.
`timescale 1ns/1ps
`default_nettype none
module mfpe_sva (
    input wire logic        ref_clk,
    input wire logic        sys_rst,
    input wire logic        select_frame_family_cmd,
    input wire logic [1:0]  family_sel,
    input wire logic        configure_frame_params_cmd,
    input wire logic [3:0]  preamble_nibble_count,
    input wire logic [15:0] css_preamble_symbols,
    input wire logic        start_tx,
    input wire logic        start_rx,
    input wire logic        mod_ready,
    input wire logic        mod_valid,
    input wire logic [7:0]  mod_byte,
    input wire logic [1:0]  mod_field,
    input wire logic        buf_rd,
    input wire logic        tx_active,
    input wire logic        rx_active,
    input wire logic        frame_done,
    input wire logic [1:0]  family,
    input wire logic [15:0] preamble_units
);
////////////////////////////////////////
    logic        idle;
    logic        cfg;
    logic [3:0]  nib_c;
    logic [15:0] css_c;
    assign idle = !tx_active && !rx_active;
    assign cfg = configure_frame_params_cmd && idle && !select_frame_family_cmd;
    assign nib_c = (preamble_nibble_count < mfpe_pkg::PRE_NIB_MIN) ? mfpe_pkg::PRE_NIB_MIN :
        (preamble_nibble_count > mfpe_pkg::PRE_NIB_MAX) ? mfpe_pkg::PRE_NIB_MAX :
        preamble_nibble_count;
    assign css_c = (css_preamble_symbols < mfpe_pkg::CSS_PRE_MIN) ? mfpe_pkg::CSS_PRE_MIN :
        css_preamble_symbols;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
////////////////////////////////////////
    a_half_duplex: assert property (!(tx_active && rx_active))
        else $error("transmit and receive active together");
    a_rx_no_mod: assert property (rx_active |-> !mod_valid)
        else $error("modulator beat during receive");
    a_valid_hold: assert property (mod_valid && !mod_ready |=>
        mod_valid && $stable(mod_byte) && $stable(mod_field)) else $error("beat dropped");
    a_done_pulse: assert property (frame_done |=> !frame_done)
        else $error("frame done longer than one cycle");
    a_tx_start: assert property (start_tx && idle |=> tx_active && !rx_active)
        else $error("transmit start not taken");
    a_rx_start: assert property (start_rx && !start_tx && idle |=> rx_active)
        else $error("receive start not taken");
    a_family_set: assert property (select_frame_family_cmd && idle |=>
        family == $past(family_sel)) else $error("family not latched");
    a_family_busy: assert property (tx_active && $past(tx_active) |-> $stable(family))
        else $error("family changed in frame");
    a_fsk_pre: assert property (cfg && family == mfpe_pkg::FAM_FSK |=>
        preamble_units == {12'h000, $past(nib_c)}) else $error("fsk preamble wrong");
    a_css_pre: assert property (cfg && family == mfpe_pkg::FAM_CSS |=>
        preamble_units == $past(css_c)) else $error("spread preamble wrong");
    a_rd_in_tx: assert property (buf_rd |-> tx_active)
        else $error("buffer read outside transmit");
    c_frame: cover property (frame_done && !rx_active);
    c_stall: cover property (mod_valid && !mod_ready);
    c_both: cover property (start_tx && start_rx && idle);
endmodule
bind mfpe_engine mfpe_sva chk_u (.*);
`default_nettype wire

// [tb/mfpe_mod_model.sv]
// Modulator-side model that may stall, counts every accepted beat and logs the bytes of field 2 beats.
`timescale 1ns/1ps
`default_nettype none
module mfpe_mod_model (
    input  wire logic       ref_clk,
    input  wire logic       clr,
    input  wire logic       slow,
    input  wire logic       mod_valid,
    input  wire logic [7:0] mod_byte,
    input  wire logic [1:0] mod_field,
    output logic            mod_ready
);
    int         cnt [4];
    logic [7:0] log_b [64];
    initial mod_ready = 1'b0;
    // Stalling on alternate cycles exercises the hold of a pending beat.
    always @(posedge ref_clk) begin
        if (clr) begin
            cnt <= '{0, 0, 0, 0};
        end else if (mod_valid && mod_ready) begin
            cnt[mod_field] <= cnt[mod_field] + 1;
            if (mod_field == 2'h2) begin
                log_b[cnt[2]] <= mod_byte;
            end
        end
        mod_ready <= slow ? !mod_ready : 1'b1;
    end
endmodule
`default_nettype wire

// [tb/multi_format_packet_engine_test.sv]
// Self-checking testbench for the multi-format packet engine.
`timescale 1ns/1ps
`default_nettype none
module multi_format_packet_engine_test;
    logic        ref_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        sel_cmd = 1'b0;
    logic        cfg_cmd = 1'b0;
    logic        start_tx = 1'b0;
    logic        start_rx = 1'b0;
    logic [1:0]  fam_sel = 2'h0;
    logic [7:0]  len = 8'h00;
    logic [3:0]  nib = 4'h4;
    logic [15:0] css = 16'h000c;
    logic        var_len = 1'b0;
    logic        whiten = 1'b0;
    logic        crc_en = 1'b1;
    logic        clr = 1'b0;
    logic        slow = 1'b0;
    logic [7:0]  buf_rd_data = 8'h00;
    logic [7:0]  rd_n = 8'h00;
    logic        mod_valid, mod_ready, buf_rd, tx_active, rx_active, frame_done, wr, cok;
    logic        rx_v = 1'b0;
    logic [7:0]  rx_b = 8'h00, wd, wr_n = 8'h00;
    logic [7:0]  mod_byte;
    logic [1:0]  mod_field, family;
    logic [15:0] preamble_units;
    int          err_count = 0;
    int          compares = 0;
    int          cyc = 0;
    mfpe_engine dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .select_frame_family_cmd(sel_cmd),
        .family_sel(fam_sel), .configure_frame_params_cmd(cfg_cmd),
        .fixed_frame_byte_count(len), .preamble_nibble_count(nib), .css_preamble_symbols(css),
        .variable_length(var_len), .whiten_enable(whiten), .crc_enable(crc_en),
        .coded_crc_bytes(3'h2), .coding_rate(2'h1), .coded_type_field(2'h0),
        .start_tx(start_tx), .start_rx(start_rx), .buf_rd_data(buf_rd_data),
        .air_rx_valid(rx_v), .air_rx_byte(rx_b), .mod_ready(mod_ready), .mod_valid(mod_valid),
        .mod_byte(mod_byte), .mod_field(mod_field), .buf_rd(buf_rd), .buf_wr(wr),
        .buf_wr_data(wd), .tx_active(tx_active), .rx_active(rx_active), .crc_ok(cok),
        .frame_done(frame_done), .header_err(), .family(family), .preamble_units(preamble_units));
    mfpe_mod_model mod_u (.ref_clk(ref_clk), .clr(clr), .slow(slow), .mod_valid(mod_valid),
        .mod_byte(mod_byte), .mod_field(mod_field), .mod_ready(mod_ready));
////////////////////////////////////////
    always #20 ref_clk = ~ref_clk;
    // Host-written buffer: the pattern stands in for payload bytes the host supplies.
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            print_verdict();
        end
        if (clr) begin
            rd_n <= 8'h00;
        end else if (buf_rd) begin
            buf_rd_data <= 8'ha0 + rd_n;
            rd_n <= rd_n + 8'h01;
        end
        if (wr) begin
            wr_n <= wr_n + 8'h01;
        end
    end
////////////////////////////////////////
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask
    task automatic cmd(input logic c, input logic [1:0] f, input logic [3:0] n,
        input logic [15:0] s);
        @(posedge ref_clk);
        fam_sel <= f;
        nib <= n;
        css <= s;
        sel_cmd <= !c;
        cfg_cmd <= c;
        @(posedge ref_clk);
        sel_cmd <= 1'b0;
        cfg_cmd <= 1'b0;
        @(posedge ref_clk);
    endtask
    // A probe run also starts receive and tries a family change mid-frame.
    task automatic send(input logic [7:0] l, input logic probe);
        int i;
        @(posedge ref_clk);
        len <= l;
        start_tx <= 1'b1;
        start_rx <= probe;
        clr <= 1'b1;
        @(posedge ref_clk);
        start_tx <= 1'b0;
        start_rx <= 1'b0;
        clr <= 1'b0;
        sel_cmd <= probe;
        fam_sel <= 2'h3;
        @(posedge ref_clk);
        sel_cmd <= 1'b0;
        if (probe) begin
            check("rx_active", 1'b0, rx_active);
            check("tx_active", 1'b1, tx_active);
        end
        for (i = 0; i < 3000 && frame_done !== 1'b1; i++) begin
            @(posedge ref_clk);
        end
        repeat (3) @(posedge ref_clk);
    endtask
    task automatic beats(input int s, input int p, input int c);
        check("sync beats", s, mod_u.cnt[1]);
        check("payload beats", p, mod_u.cnt[2]);
        check("crc beats", c, mod_u.cnt[3]);
    endtask
    task automatic pay(input int off, input int n);
        for (int i = 0; i < n; i++) begin
            check("payload byte", 8'ha0 + i[7:0], mod_u.log_b[i + off]);
        end
    endtask
    task automatic print_verdict;
        if (err_count == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
////////////////////////////////////////
    initial begin
        logic [3:0] nt [5];
        logic [3:0] e;
        logic       d;
        nt = '{4'h0, 4'h1, 4'h3, 4'h8, 4'h9};
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        check("family", mfpe_pkg::FAM_FSK, family);
        check("preamble_units", mfpe_pkg::CSS_PRE_DEFAULT, preamble_units);
        for (int f = 0; f < 4; f++) begin
            cmd(1'b0, f[1:0], 4'h4, 16'h000c);
            check("family", f[1:0], family);
        end
        cmd(1'b1, 2'h0, 4'h0, 16'h0005);
        check("css preamble", mfpe_pkg::CSS_PRE_MIN, preamble_units);
        cmd(1'b1, 2'h0, 4'h0, 16'hffff);
        check("css preamble", 16'hffff, preamble_units);
        cmd(1'b0, mfpe_pkg::FAM_FSK, 4'h4, 16'h000c);
        for (int i = 0; i < 5; i++) begin
            e = (nt[i] < mfpe_pkg::PRE_NIB_MIN) ? mfpe_pkg::PRE_NIB_MIN :
                (nt[i] > mfpe_pkg::PRE_NIB_MAX) ? mfpe_pkg::PRE_NIB_MAX : nt[i];
            cmd(1'b1, 2'h0, nt[i], 16'h000c);
            check("fsk preamble", e, preamble_units);
        end
        cmd(1'b1, 2'h0, 4'h4, 16'h000c);
        slow <= 1'b1;
        send(8'h05, 1'b0);
        beats(4, 5, 2);
        pay(0, 5);
        crc_en <= 1'b0;
        slow <= 1'b0;
        send(8'h00, 1'b1);
        beats(4, 0, 0);
        check("family", mfpe_pkg::FAM_FSK, family);
        crc_en <= 1'b1;
        var_len <= 1'b1;
        send(8'h03, 1'b0);
        beats(4, 4, 2);
        check("length byte", 8'h03, mod_u.log_b[0]);
        pay(1, 3);
        var_len <= 1'b0;
        whiten <= 1'b1;
        send(8'h04, 1'b0);
        d = 1'b0;
        for (int i = 0; i < 4; i++) begin
            d = d | (mod_u.log_b[i] !== 8'ha0 + i[7:0]);
        end
        check("whitened payload", 1'b1, d);
        whiten <= 1'b0;
        var_len <= 1'b1;
        crc_en <= 1'b0;
        start_rx <= 1'b1;
        for (int i = 0; i < 15; i++) begin
            @(posedge ref_clk);
            start_rx <= 1'b0;
            rx_v <= (i < 14);
            rx_b <= (i == 8) ? 8'h02 : 8'hb0 + i[7:0];
        end
        check("rx writes", 8'h02, wr_n);
        check("rx last byte", 8'hba, wd);
        check("rx crc_ok", 1'b1, cok);
        slow <= 1'b1;
        cmd(1'b0, mfpe_pkg::FAM_LEW, 4'h4, 16'h000c);
        send(8'h04, 1'b0);
        beats(4, 4, 3);
        pay(0, 4);
        print_verdict();
    end
endmodule
`default_nettype wire
